// *** svil_shared_irq.sv ***
// Serial and shared-vector interrupt request logic with tick dividers and AXI4-Lite registers
//
// Functional notes
// - Conversion-done interrupts need global, conversion and group enables all set.
// - Conversion completion sets the conversion-done flag.
// - Enabled group request with stack not full calls vector 018H.
// - Servicing the group clears group flag and global enable, keeps member flags.
// - Serial interrupt allowed only with global and serial enables set.
// - Each serial byte sets the serial flag; enabled, it calls vector 14H.
// - Servicing the serial interrupt clears its flag and the global enable.
// - Time-base, clock, conversion or peripheral events set the group flag when their own enables are set.
// - Group interrupt allowed only with global and group enables set.
// - Clock divider overflow sets its flag; interrupts with three enables set.
// - Clock divider ratio 2^8 to 2^15, chosen by a three-bit field.
// - Tick source is clock oscillator, slow oscillator, or system clock over four.
// - Time-base overflow sets its flag; interrupts with three enables set.
// - Time-base ratio 2^12 to 2^15, fixed by a configuration input.
// - A set flag holds, enable or not, until serviced or cleared.
// - Every source here can wake the processor from power-down.
// - Entry pushes only the program counter, nothing else.
// - Fixed priority: higher sources first, serial fifth, group sixth.
// - No request is acknowledged while the return stack is full.
// - Falling edge on the peripheral pin sets the peripheral flag.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "svil_consts.svh"
module svil_shared_irq
	import svil_pkg::*;
#(
	parameter int DIV_WIDTH = 15
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire svil_events_t events,
	input wire logic ext_periph_pin,
	input wire logic rtc_osc,
	input wire logic internal_slow_osc,
	input wire svil_fs_src_t fs_source_cfg,
	input wire logic [1:0] tb_ratio_cfg,
	input wire logic stack_full,
	input wire logic higher_pri_pending,
	output svil_call_t call,
	input wire logic call_ack,
	output logic push_pc,
	output logic wake
);
	if (DIV_WIDTH < `SVIL_RTC_EXP_MAX || DIV_WIDTH > 31) begin : g_width_check
		$error("DIV_WIDTH too small for longest ratio");
	end

	// Control and flag state
	logic global_int_enable;
	logic serial_int_enable;
	logic shared_group_enable;
	logic serial_int_flag;
	logic shared_group_flag;
	logic conv_done_int_enable;
	logic rtc_tick_enable;
	logic periodic_tick_enable;
	logic ext_periph_enable;
	logic conv_done_flag;
	logic rtc_tick_flag;
	logic periodic_tick_flag;
	logic ext_periph_flag;
	logic [2:0] rtc_divider_control;

	// Bus state
	logic aw_held;
	logic w_held;
	logic [`SVIL_ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic do_write;
	logic wr_ctrl_a;
	logic wr_group;
	logic wr_rtc;
	logic addr_ok;
	logic [`SVIL_ADDR_W-1:0] rd_addr;
	logic [31:0] next_rdata;
	logic next_rresp_err;

	// Event and service terms
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic fs_tick;
	logic [1:0] sys_div;
	logic rtc_overflow;
	logic tb_overflow;
	logic [2:0] tb_exp;
	logic group_event;
	logic serial_req;
	logic group_req;
	logic take;
	logic take_serial;
	logic take_group;

	// Tick source and peripheral pin synchronisation and edges
	svil_sync_edge #(
		.WIDTH(3)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({ext_periph_pin, internal_slow_osc, rtc_osc}),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_div <= 2'h0;
		end else begin
			sys_div <= sys_div + 2'h1;
		end
	end

	always_comb begin
		unique case (fs_source_cfg)
			SVIL_FS_RTC_OSC: fs_tick = pin_rise[0];
			SVIL_FS_SLOW_OSC: fs_tick = pin_rise[1];
			SVIL_FS_SYS_DIV4: fs_tick = (sys_div == 2'(`SVIL_SYS_DIV - 1));
			default: fs_tick = 1'b0;
		endcase
	end

	// Both dividers advance only on the selected tick; with no tick source selected they hold
	svil_tick_divider #(
		.WIDTH(DIV_WIDTH),
		.EXP_MIN(`SVIL_RTC_EXP_MIN)
	) u_rtc_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_en(fs_tick),
		.exp_sel(rtc_divider_control),
		.overflow(rtc_overflow)
	);

	assign tb_exp = {1'b0, tb_ratio_cfg};

	svil_tick_divider #(
		.WIDTH(DIV_WIDTH),
		.EXP_MIN(`SVIL_TB_EXP_MIN)
	) u_tb_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_en(fs_tick),
		.exp_sel(tb_exp),
		.overflow(tb_overflow)
	);

	// Member events reach the group only through their own enables
	assign group_event = (events.conv_done & conv_done_int_enable)
		| (rtc_overflow & rtc_tick_enable)
		| (tb_overflow & periodic_tick_enable)
		| (pin_fall[2] & ext_periph_enable);

	// Request arbitration
	assign serial_req = global_int_enable & serial_int_enable & serial_int_flag;
	assign group_req = global_int_enable & shared_group_enable & shared_group_flag;
	assign take = call.valid & call_ack;
	assign take_serial = take && (call.vector == `SVIL_VEC_SERIAL);
	assign take_group = take && (call.vector == `SVIL_VEC_SHARED);
	assign push_pc = take;

	// Offer recomputed each cycle; dropped on the accepting edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			call <= '0;
		end else if (take || stack_full || higher_pri_pending) begin
			call.valid <= 1'b0;
		end else if (serial_req) begin
			call.valid <= 1'b1;
			call.vector <= `SVIL_VEC_SERIAL;
		end else if (group_req) begin
			call.valid <= 1'b1;
			call.vector <= `SVIL_VEC_SHARED;
		end else begin
			call.valid <= 1'b0;
		end
	end

	// Wake needs the source enables only, not the global enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake <= 1'b0;
		end else begin
			wake <= (serial_int_enable & serial_int_flag) | (shared_group_enable & shared_group_flag);
		end
	end

	// Write path
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign wr_ctrl_a = do_write & w_lane0 & (aw_addr == `SVIL_OFS_CTRL_A);
	assign wr_group = do_write & w_lane0 & (aw_addr == `SVIL_OFS_GROUP);
	assign wr_rtc = do_write & w_lane0 & (aw_addr == `SVIL_OFS_RTC);
	assign addr_ok = (aw_addr == `SVIL_OFS_CTRL_A) | (aw_addr == `SVIL_OFS_GROUP)
		| (aw_addr == `SVIL_OFS_RTC) | (aw_addr == `SVIL_OFS_STATUS);
	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr[`SVIL_ADDR_W-1:0];
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SVIL_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= addr_ok ? `SVIL_RESP_OKAY : `SVIL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Enables; service clearing of the global enable beats a software write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_int_enable <= 1'(`SVIL_CTRL_A_RST >> `SVIL_A_GIE);
			serial_int_enable <= 1'b0;
			shared_group_enable <= 1'b0;
		end else begin
			if (wr_ctrl_a) begin
				serial_int_enable <= w_byte[`SVIL_A_SIE];
				shared_group_enable <= w_byte[`SVIL_A_SGE];
			end
			if (take) begin
				global_int_enable <= 1'b0;
			end else if (wr_ctrl_a) begin
				global_int_enable <= w_byte[`SVIL_A_GIE];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_done_int_enable <= 1'b0;
			rtc_tick_enable <= 1'b0;
			periodic_tick_enable <= 1'b0;
			ext_periph_enable <= 1'b0;
			rtc_divider_control <= `SVIL_RTC_RST;
		end else begin
			if (wr_group) begin
				conv_done_int_enable <= w_byte[`SVIL_G_CDE];
				rtc_tick_enable <= w_byte[`SVIL_G_RTE];
				periodic_tick_enable <= w_byte[`SVIL_G_PTE];
				ext_periph_enable <= w_byte[`SVIL_G_EPE];
			end
			if (wr_rtc) begin
				rtc_divider_control <= w_byte[2:0];
			end
		end
	end

	// Vector flags: an event in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_int_flag <= 1'b0;
			shared_group_flag <= 1'b0;
		end else begin
			if (events.serial_done) begin
				serial_int_flag <= 1'b1;
			end else if (take_serial) begin
				serial_int_flag <= 1'b0;
			end else if (wr_ctrl_a) begin
				serial_int_flag <= w_byte[`SVIL_A_SIF];
			end
			if (group_event) begin
				shared_group_flag <= 1'b1;
			end else if (take_group) begin
				shared_group_flag <= 1'b0;
			end else if (wr_ctrl_a) begin
				shared_group_flag <= w_byte[`SVIL_A_SGF];
			end
		end
	end

	// Member flags are set regardless of enables and cleared only by software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_done_flag <= 1'b0;
			rtc_tick_flag <= 1'b0;
			periodic_tick_flag <= 1'b0;
			ext_periph_flag <= 1'b0;
		end else begin
			if (events.conv_done) begin
				conv_done_flag <= 1'b1;
			end else if (wr_group) begin
				conv_done_flag <= w_byte[`SVIL_G_CDF];
			end
			if (rtc_overflow) begin
				rtc_tick_flag <= 1'b1;
			end else if (wr_group) begin
				rtc_tick_flag <= w_byte[`SVIL_G_RTF];
			end
			if (tb_overflow) begin
				periodic_tick_flag <= 1'b1;
			end else if (wr_group) begin
				periodic_tick_flag <= w_byte[`SVIL_G_PTF];
			end
			if (pin_fall[2]) begin
				ext_periph_flag <= 1'b1;
			end else if (wr_group) begin
				ext_periph_flag <= w_byte[`SVIL_G_EPF];
			end
		end
	end

	// Read path
	assign rd_addr = s_axi_araddr[`SVIL_ADDR_W-1:0];
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp_err = 1'b0;
		unique case (rd_addr)
			`SVIL_OFS_CTRL_A: begin
				next_rdata[`SVIL_A_GIE] = global_int_enable;
				next_rdata[`SVIL_A_SIE] = serial_int_enable;
				next_rdata[`SVIL_A_SGE] = shared_group_enable;
				next_rdata[`SVIL_A_SIF] = serial_int_flag;
				next_rdata[`SVIL_A_SGF] = shared_group_flag;
			end
			`SVIL_OFS_GROUP: begin
				next_rdata[`SVIL_G_CDE] = conv_done_int_enable;
				next_rdata[`SVIL_G_RTE] = rtc_tick_enable;
				next_rdata[`SVIL_G_PTE] = periodic_tick_enable;
				next_rdata[`SVIL_G_EPE] = ext_periph_enable;
				next_rdata[`SVIL_G_CDF] = conv_done_flag;
				next_rdata[`SVIL_G_RTF] = rtc_tick_flag;
				next_rdata[`SVIL_G_PTF] = periodic_tick_flag;
				next_rdata[`SVIL_G_EPF] = ext_periph_flag;
			end
			`SVIL_OFS_RTC: next_rdata[2:0] = rtc_divider_control;
			`SVIL_OFS_STATUS: next_rdata[9:0] = {wake, call.valid, call.vector};
			default: next_rresp_err = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SVIL_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp_err ? `SVIL_RESP_SLVERR : `SVIL_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // svil_shared_irq

// *** svil_consts.svh ***
// Register offsets, field positions, reset values and divider counts for the shared-vector interrupt logic
`ifndef SVIL_CONSTS_SVH
`define SVIL_CONSTS_SVH

`define SVIL_ADDR_W 4
`define SVIL_OFS_CTRL_A 4'h0
`define SVIL_OFS_GROUP 4'h4
`define SVIL_OFS_RTC 4'h8
`define SVIL_OFS_STATUS 4'hC

`define SVIL_A_GIE 0
`define SVIL_A_SIE 1
`define SVIL_A_SGE 2
`define SVIL_A_SIF 4
`define SVIL_A_SGF 5

`define SVIL_G_CDE 0
`define SVIL_G_RTE 1
`define SVIL_G_PTE 2
`define SVIL_G_EPE 3
`define SVIL_G_CDF 4
`define SVIL_G_RTF 5
`define SVIL_G_PTF 6
`define SVIL_G_EPF 7

`define SVIL_CTRL_A_RST 8'h00
`define SVIL_GROUP_RST 8'h00
`define SVIL_RTC_RST 3'h0

`define SVIL_VEC_SERIAL 8'h14
`define SVIL_VEC_SHARED 8'h18

`define SVIL_SYS_DIV 4
`define SVIL_RTC_EXP_MIN 8
`define SVIL_RTC_EXP_MAX 15
`define SVIL_TB_EXP_MIN 12
`define SVIL_TB_EXP_MAX 15

`define SVIL_RESP_OKAY 2'h0
`define SVIL_RESP_SLVERR 2'h2

`endif

// *** svil_pkg.sv ***
// Types shared by the shared-vector interrupt logic
package svil_pkg;

	typedef enum logic [1:0] {
		SVIL_FS_RTC_OSC,
		SVIL_FS_SLOW_OSC,
		SVIL_FS_SYS_DIV4,
		SVIL_FS_UNUSED
	} svil_fs_src_t;

	typedef struct packed {
		logic conv_done;
		logic serial_done;
	} svil_events_t;

	typedef struct packed {
		logic valid;
		logic [7:0] vector;
	} svil_call_t;

endpackage

// *** svil_sync_edge.sv ***
// Two-flop synchronisers with rising and falling edge detect, one per input bit
`timescale 1ns/1ps
module svil_sync_edge #(
	parameter int WIDTH = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	if (WIDTH < 1) begin : g_width_check
		$error("WIDTH must be at least 1");
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			logic stable;
			logic last;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta <= 1'b1;
					stable <= 1'b1;
					last <= 1'b1;
				end else begin
					meta <= async_in[i];
					stable <= meta;
					last <= stable;
				end
			end
			// Only the second stage and its delayed copy feed the detectors
			assign rise[i] = stable & ~last;
			assign fall[i] = ~stable & last;
		end
	endgenerate
endmodule // svil_sync_edge

// *** svil_tick_divider.sv ***
// Free-running power-of-two divider that pulses once per selected period
`timescale 1ns/1ps
module svil_tick_divider #(
	parameter int WIDTH = 15,
	parameter int EXP_MIN = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick_en,
	input wire logic [2:0] exp_sel,
	output logic overflow
);
	if (EXP_MIN < 1 || EXP_MIN + 7 > WIDTH + 7 || WIDTH > 31) begin : g_width_check
		$error("Divider width cannot serve the range");
	end

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] mask;
	logic [4:0] exp;

	assign exp = 5'(EXP_MIN) + {2'b00, exp_sel};
	assign mask = WIDTH'((32'h0000_0001 << exp) - 32'h0000_0001);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (tick_en) begin
			count <= count + WIDTH'(1);
		end
	end

	// Pulse on the tick that wraps the selected low bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow <= 1'b0;
		end else begin
			overflow <= tick_en && ((count & mask) == mask);
		end
	end
endmodule // svil_tick_divider

// *** svil_shared_irq_asserts.sv ***
// Port-level checks for the shared-vector interrupt logic
`timescale 1ns/1ps
`include "svil_consts.svh"
module svil_shared_irq_asserts
	import svil_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stack_full,
	input wire logic higher_pri_pending,
	input wire svil_call_t call,
	input wire logic call_ack,
	input wire logic push_pc,
	input wire logic wake
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_push_only_take: assert property (push_pc == (call.valid && call_ack))
		else $error("push_pc differs from a taken call");
	a_full_blocks_call: assert property (stack_full |=> !call.valid)
		else $error("call offered with full stack");
	a_higher_first: assert property (higher_pri_pending |=> !call.valid)
		else $error("call offered over a higher source");
	a_take_drops_call: assert property (call.valid && call_ack |=> !call.valid)
		else $error("call still offered after take");
	a_vector_legal: assert property (call.valid |-> (call.vector == `SVIL_VEC_SERIAL || call.vector == `SVIL_VEC_SHARED))
		else $error("call vector not serial or shared");
	a_call_wakes: assert property (call.valid |-> wake)
		else $error("call offered without wake");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_read_one: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	c_serial_take: cover property (call.valid && call_ack && call.vector == `SVIL_VEC_SERIAL);
	c_shared_take: cover property (call.valid && call_ack && call.vector == `SVIL_VEC_SHARED);
	c_full_wait: cover property (stack_full ##1 (!call.valid && wake));
endmodule // svil_shared_irq_asserts

// *** svil_core_model.sv ***
// Behavioural program sequencer and return stack facing the interrupt logic
`timescale 1ns/1ps
module svil_core_model
	import svil_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire svil_call_t call,
	input wire logic push_pc,
	input wire logic [1:0] stall,
	input wire logic stack_hold,
	output logic call_ack,
	output logic stack_full,
	output logic [7:0] taken_vec,
	output logic [15:0] taken_cnt,
	output logic [15:0] pc_top
);
	logic [1:0] wait_cnt;
	logic [15:0] pc;
	assign stack_full = stack_hold;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			call_ack <= 1'b0;
			wait_cnt <= 2'h0;
		end else if (call_ack) begin
			call_ack <= 1'b0;
		end else if (call.valid && !stack_full) begin
			// Slow answers keep the offer standing a few cycles
			if (wait_cnt >= stall) begin
				call_ack <= 1'b1;
				wait_cnt <= 2'h0;
			end else begin
				wait_cnt <= wait_cnt + 2'h1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc <= 16'h0000;
			pc_top <= 16'h0000;
			taken_vec <= 8'h00;
			taken_cnt <= 16'h0000;
		end else begin
			pc <= pc + 16'h0001;
			// Only the program counter goes on the stack
			if (push_pc) begin
				pc_top <= pc;
				taken_vec <= call.vector;
				taken_cnt <= taken_cnt + 16'h0001;
			end
		end
	end
endmodule // svil_core_model

// *** shared_vector_interrupt_logic_tb.sv ***
// Self-checking bench for the shared-vector interrupt logic
`timescale 1ns/1ps
`include "svil_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module shared_vector_interrupt_logic_tb
	import svil_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_periph_pin, stack_full, stack_hold;
	logic higher_pri_pending, call_ack, push_pc, wake, rtc_osc, internal_slow_osc;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, tb_ratio_cfg, stall;
	logic [7:0] taken_vec, lfsr_q;
	logic [15:0] taken_cnt, pc_top;
	svil_events_t events;
	svil_fs_src_t fs_source_cfg;
	svil_call_t call;
	int failures, checked, cyc, seen, ctrl_m, grp_m, rtc_m;
	svil_shared_irq svil_shared_irq_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events,
		.ext_periph_pin, .rtc_osc, .internal_slow_osc, .fs_source_cfg, .tb_ratio_cfg, .stack_full,
		.higher_pri_pending, .call, .call_ack, .push_pc, .wake);
	svil_core_model svil_core_model_i (.aclk, .aresetn, .call, .push_pc, .stall, .stack_hold, .call_ack,
		.stack_full, .taken_vec, .taken_cnt, .pc_top);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [1:0] ok(input logic [3:0] a);
		return (a[1:0] == 2'b00) ? `SVIL_RESP_OKAY : `SVIL_RESP_SLVERR;
	endfunction
	// Offered vector predicted from the software-visible model
	function automatic int want();
		if (ctrl_m[0] && ctrl_m[1] && ctrl_m[4]) return 'h14;
		if (ctrl_m[0] && ctrl_m[2] && ctrl_m[5]) return 'h18;
		return 0;
	endfunction
	function automatic logic wake_m();
		return (ctrl_m[1] && ctrl_m[4]) || (ctrl_m[2] && ctrl_m[5]);
	endfunction
	task automatic final_report();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic aw;
		logic w;
		@(posedge aclk);
		s_axi_awaddr <= {28'h000_0000, a};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		do begin
			@(posedge aclk);
			if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
		end while (aw || w);
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, ok(a))
		// Without lane 0 the write is answered but changes nothing
		if (s_axi_wstrb[0] && a == `SVIL_OFS_CTRL_A) ctrl_m = d & 8'h37;
		if (s_axi_wstrb[0] && a == `SVIL_OFS_GROUP) grp_m = d;
		if (s_axi_wstrb[0] && a == `SVIL_OFS_RTC) rtc_m = d & 8'h07;
	endtask
	task automatic rd_chk(input logic [3:0] a, input int e);
		@(posedge aclk);
		s_axi_araddr <= {28'h000_0000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, e[31:0])
		`CHK(s_axi_rresp, ok(a))
	endtask
	task automatic fire(input svil_events_t e);
		@(posedge aclk);
		events <= e;
		@(posedge aclk);
		events <= '0;
		if (e.serial_done) ctrl_m |= 'h10;
		if (e.conv_done) grp_m |= 'h10;
		if (e.conv_done && grp_m[0]) ctrl_m |= 'h20;
	endtask
	task automatic idle();
		repeat (8) @(posedge aclk);
		`CHK(call.valid, 1'b0)
		`CHK(taken_cnt, seen[15:0])
	endtask
	task automatic take();
		int v;
		int n;
		v = want();
		stall <= lfsr_q[1:0];
		lfsr_q = lfsr(lfsr_q);
		n = 0;
		while (taken_cnt == seen[15:0] && n < 200) begin
			@(posedge aclk);
			n++;
		end
		seen++;
		`CHK(taken_cnt, seen[15:0])
		`CHK(taken_vec, v[7:0])
		ctrl_m &= (v == 'h14) ? ~'h11 : ~'h21;
	endtask
	// Interval between two overflow-driven wake rises, flag cleared in between
	task automatic period(input logic [7:0] g, input logic [2:0] r, input int e);
		int t1;
		int t2;
		int n;
		wr(`SVIL_OFS_RTC, {5'h00, r});
		wr(`SVIL_OFS_GROUP, g);
		for (int k = 0; k < 3; k++) begin
			wr(`SVIL_OFS_CTRL_A, 8'h04);
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!wake && n < 3 * e);
			t1 = t2;
			t2 = cyc;
		end
		`CHK(t2 - t1, e)
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;
	// Free-running slow oscillators: one tick every 4 and every 8 cycles
	always @(posedge aclk) {internal_slow_osc, rtc_osc} <= {cyc[2], cyc[1]};
	initial begin
		repeat (95000) @(posedge aclk);
		failures++;
		final_report();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{stack_hold, higher_pri_pending} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		tb_ratio_cfg = 2'h0;
		stall = 2'h0;
		events = '0;
		ext_periph_pin = 1'b1;
		// No ticks until the divider checks, so the clock and time-base member flags stay quiet
		fs_source_cfg = SVIL_FS_UNUSED;
		lfsr_q = 8'h50;
		{failures, checked, cyc, seen, ctrl_m, grp_m, rtc_m} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd_chk({i[1:0], 2'b00}, 0);
		rd_chk(4'h2, 0);
		wr(4'h2, 8'h01);
		for (int i = 0; i < 4; i++) begin
			lfsr_q = lfsr(lfsr_q);
			wr(`SVIL_OFS_RTC, lfsr_q);
			rd_chk(`SVIL_OFS_RTC, rtc_m);
		end
		s_axi_wstrb <= 4'hE;
		wr(`SVIL_OFS_RTC, ~rtc_m[7:0]);
		s_axi_wstrb <= 4'hF;
		rd_chk(`SVIL_OFS_RTC, rtc_m);
		wr(`SVIL_OFS_GROUP, 8'h01);
		wr(`SVIL_OFS_CTRL_A, 8'h01);
		fire(svil_events_t'(2'b11));
		idle();
		rd_chk(`SVIL_OFS_CTRL_A, ctrl_m);
		rd_chk(`SVIL_OFS_GROUP, grp_m);
		`CHK(wake, wake_m())
		wr(`SVIL_OFS_CTRL_A, 8'h37);
		take();
		rd_chk(`SVIL_OFS_CTRL_A, ctrl_m);
		`CHK(wake, wake_m())
		stack_hold <= 1'b1;
		wr(`SVIL_OFS_CTRL_A, 8'h27);
		idle();
		stack_hold <= 1'b0;
		take();
		rd_chk(`SVIL_OFS_CTRL_A, ctrl_m);
		rd_chk(`SVIL_OFS_GROUP, grp_m);
		wr(`SVIL_OFS_GROUP, 8'h00);
		wr(`SVIL_OFS_CTRL_A, 8'h05);
		fire(svil_events_t'(2'b10));
		idle();
		rd_chk(`SVIL_OFS_GROUP, grp_m);
		wr(`SVIL_OFS_GROUP, 8'h01);
		higher_pri_pending <= 1'b1;
		fire(svil_events_t'(2'b10));
		idle();
		higher_pri_pending <= 1'b0;
		take();
		wr(`SVIL_OFS_GROUP, 8'h08);
		ext_periph_pin <= 1'b0;
		grp_m |= 'h80;
		ctrl_m |= 'h20;
		repeat (8) @(posedge aclk);
		rd_chk(`SVIL_OFS_GROUP, grp_m);
		rd_chk(`SVIL_OFS_CTRL_A, ctrl_m);
		rd_chk(`SVIL_OFS_STATUS, {wake_m(), 9'h018});
		ext_periph_pin <= 1'b1;
		fs_source_cfg <= SVIL_FS_SYS_DIV4;
		period(8'h02, 3'h0, 1024);
		period(8'h02, 3'h1, 2048);
		fs_source_cfg <= SVIL_FS_RTC_OSC;
		period(8'h02, 3'h0, 1024);
		fs_source_cfg <= SVIL_FS_SLOW_OSC;
		period(8'h02, 3'h0, 2048);
		fs_source_cfg <= SVIL_FS_SYS_DIV4;
		period(8'h04, 3'h0, 16384);
		final_report();
	end
endmodule // shared_vector_interrupt_logic_tb
bind svil_shared_irq svil_shared_irq_asserts svil_shared_irq_asserts_i (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .stack_full,
	.higher_pri_pending, .call, .call_ack, .push_pc, .wake);
